// ===== rtl/tcp_map.svh
// Offsets, field positions, reset values and timing counts of the torque command path.
// Assumes a 32-bit APB register bus and a 100 MHz pclk.
`ifndef TCP_MAP_SVH
`define TCP_MAP_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define TCP_OFS_CTRL     12'h000
`define TCP_OFS_SETPOINT 12'h004
`define TCP_OFS_BIAS     12'h008
`define TCP_OFS_AFILT    12'h00C
`define TCP_OFS_DEAD     12'h010
`define TCP_OFS_OFFSET   12'h014
`define TCP_OFS_TFILT    12'h018
`define TCP_OFS_FWD      12'h01C
`define TCP_OFS_REV      12'h020
`define TCP_OFS_STATUS   12'h024
`define TCP_OFS_CMDOUT   12'h028

// ----------------------------------------------------------------
// Control and status fields
// ----------------------------------------------------------------
`define TCP_CTRL_SRC     0
`define TCP_CTRL_LIM     1
`define TCP_CTRL_CAL     2
`define TCP_CTRL_ADJ_LO  4
`define TCP_CTRL_ADJ_HI  7
`define TCP_STAT_LIMITED 0
`define TCP_STAT_ANALOG  1

// ----------------------------------------------------------------
// Ranges and reset values
// ----------------------------------------------------------------
`define TCP_TRQ_MAX      32'sh00000BB8
`define TCP_OFFSET_MAX   32'sh000001F4
`define TCP_BIAS_MAX     32'sh00001388
`define TCP_DEAD_MAX     32'sh000003E8
`define TCP_AFILT_MAX    32'sh0000EA60
`define TCP_TFILT_MIN    32'sh0000000A
`define TCP_TFILT_MAX    32'sh000009C4
`define TCP_AI_FULL_MV   32'sh00002710
`define TCP_AI_GAIN_NUM  32'sh00000003
`define TCP_AI_GAIN_DEN  32'sh0000000A
`define TCP_RST_AFILT    16'h00C8
`define TCP_RST_DEAD     16'h0014
`define TCP_RST_TFILT    16'h0032
`define TCP_RST_LIMIT    16'h0BB8
`define TCP_RST_ADJ      4'h1
`define TCP_TFILT_AUTO   16'h0032

// ----------------------------------------------------------------
// Filter tick
// ----------------------------------------------------------------
`define TCP_CLK_NS       10
`define TCP_TICK_NS      10000
`define TCP_TICK_CYC     (`TCP_TICK_NS / `TCP_CLK_NS)

`endif

// ===== rtl/tcp_pkg.sv
// Types shared by the torque command path modules.
// Assumes the constants of tcp_map.svh alongside.
package tcp_pkg;

	typedef logic signed [15:0] tcp_val_t;

	typedef enum logic {
		TCP_SRC_INTERNAL,
		TCP_SRC_ANALOG
	} tcp_src_e;

endpackage

// ===== rtl/tcp_lpf.sv
// First-order low-pass filter stepped by a periodic tick.
// Assumes tau in ticks and an input that is stable around each tick.
`timescale 1ns/10ps

module tcp_lpf (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             tick,
	input  wire logic [15:0]      tau,
	input  wire tcp_pkg::tcp_val_t x,
	output tcp_pkg::tcp_val_t      y
);
	import tcp_pkg::*;

	// ----------------------------------------------------------------
	// Step size
	// ----------------------------------------------------------------
	// The gain is rounded to a power of two so no divider is needed.
	logic        [16:0] tau1;
	logic        [4:0]  k;
	logic signed [31:0] xs;
	logic signed [32:0] err;
	logic signed [31:0] acc_q;
	logic signed [31:0] acc_d;

	assign tau1 = {1'b0, tau} + 17'h00001;
	assign xs   = {x, 16'h0000};
	assign err  = 33'(xs) - 33'(acc_q);

	always_comb begin
		k = 5'h00;
		for (int i = 0; i < 17; i++) begin
			if (tau1[i]) begin
				k = 5'(i);
			end
		end
	end

	assign acc_d = (tau == 16'h0000) ? xs : acc_q + 32'(err >>> k);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			acc_q <= 32'sh00000000;
		end else if (tick) begin
			acc_q <= acc_d;
		end
	end

	assign y = acc_q[31:16];

endmodule

// ===== rtl/tcp_clamp.sv
// Clamps a signed torque value between a forward and a reverse magnitude.
// Assumes both magnitudes already lie within the rated range.
`timescale 1ns/10ps

module tcp_clamp (
	input  wire tcp_pkg::tcp_val_t x,
	input  wire logic [15:0]      fwd,
	input  wire logic [15:0]      rev,
	output tcp_pkg::tcp_val_t      y,
	output logic                  hit
);
	import tcp_pkg::*;

	logic signed [16:0] xe;
	logic signed [16:0] fe;
	logic signed [16:0] re;
	logic               hi;
	logic               lo;

	assign xe  = 17'(x);
	assign fe  = $signed({1'b0, fwd});
	assign re  = -$signed({1'b0, rev});
	assign hi  = xe >= fe;
	assign lo  = xe <= re;
	// A command at the limit counts as limited as well.
	assign y   = hi ? $signed(fwd) : (lo ? 16'(re) : x);
	assign hit = hi | lo;

endmodule

// ===== rtl/tcp_top.sv
// Torque command path: source choice, analog conditioning, filtering and limiting.
// Assumes analog samples in mV arrive already synchronous to pclk from the converter.
//
// Added by the designer: the APB register port and the register addresses.
`timescale 1ns/10ps
`include "tcp_map.svh"

module tcp_top #(
	parameter logic HAS_ANALOG = 1'b1
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             psel,
	input  wire logic             penable,
	input  wire logic             pwrite,
	input  wire logic [11:0]      paddr,
	input  wire logic [31:0]      pwdata,
	output logic [31:0]           prdata,
	output logic                  pready,
	output logic                  pslverr,
	input  wire tcp_pkg::tcp_val_t analog_channel_one,
	input  wire tcp_pkg::tcp_val_t analog_channel_two,
	output tcp_pkg::tcp_val_t      torque_command_out,
	output logic                  torque_limited
);
	import tcp_pkg::*;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic tcp_val_t sat(input logic signed [31:0] v,
		input logic signed [31:0] lo, input logic signed [31:0] hi);
		logic signed [31:0] r;
		r = v;
		if (v < lo) begin
			r = lo;
		end
		if (v > hi) begin
			r = hi;
		end
		return r[15:0];
	endfunction

	// ----------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------
	logic        setup;
	logic        access;
	logic        wr_en;
	logic        mapped;
	logic        wr_ctrl;
	logic        wr_set;
	logic        wr_bias;
	logic        wr_afilt;
	logic        wr_dead;
	logic        wr_off;
	logic        wr_tfilt;
	logic        wr_fwd;
	logic        wr_rev;
	logic [31:0] rdata_d;
	logic [31:0] prdata_q;
	logic signed [31:0] wsig;
	logic signed [31:0] wuns;

	assign setup    = psel & ~penable;
	assign access   = psel & penable;
	assign mapped   = (paddr[1:0] == 2'h0) && (paddr <= `TCP_OFS_CMDOUT);
	assign wr_en    = access & pwrite & mapped;
	assign wr_ctrl  = wr_en && (paddr == `TCP_OFS_CTRL);
	assign wr_set   = wr_en && (paddr == `TCP_OFS_SETPOINT);
	assign wr_bias  = wr_en && (paddr == `TCP_OFS_BIAS);
	assign wr_afilt = wr_en && (paddr == `TCP_OFS_AFILT);
	assign wr_dead  = wr_en && (paddr == `TCP_OFS_DEAD);
	assign wr_off   = wr_en && (paddr == `TCP_OFS_OFFSET);
	assign wr_tfilt = wr_en && (paddr == `TCP_OFS_TFILT);
	assign wr_fwd   = wr_en && (paddr == `TCP_OFS_FWD);
	assign wr_rev   = wr_en && (paddr == `TCP_OFS_REV);
	assign wsig     = 32'($signed(pwdata[15:0]));
	assign wuns     = $signed({16'h0000, pwdata[15:0]});
	assign pready   = 1'b1;
	assign pslverr  = access & ~mapped;
	assign prdata   = prdata_q;

	// ----------------------------------------------------------------
	// Settings
	// ----------------------------------------------------------------
	tcp_src_e    src_q;
	tcp_src_e    lim_src_q;
	logic [3:0]  adj_q;
	tcp_val_t    setpoint_q;
	tcp_val_t    bias_q;
	logic [15:0] afilt_q;
	logic [15:0] dead_q;
	tcp_val_t    offset_q;
	logic [15:0] tfilt_q;
	logic [15:0] fwd_q;
	logic [15:0] rev_q;
	logic        cal_req;
	logic        auto_tf;
	tcp_val_t    cal_val;

	assign cal_req = wr_ctrl & pwdata[`TCP_CTRL_CAL];
	assign auto_tf = (adj_q == 4'h0);
	// Calibration assumes channel one sits at 0 V when it is requested.
	assign cal_val = sat(32'(analog_channel_one), -`TCP_OFFSET_MAX, `TCP_OFFSET_MAX);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			src_q     <= TCP_SRC_INTERNAL;
			lim_src_q <= TCP_SRC_INTERNAL;
			adj_q     <= `TCP_RST_ADJ;
		end else if (wr_ctrl) begin
			src_q     <= HAS_ANALOG ? tcp_src_e'(pwdata[`TCP_CTRL_SRC]) : TCP_SRC_INTERNAL;
			lim_src_q <= HAS_ANALOG ? tcp_src_e'(pwdata[`TCP_CTRL_LIM]) : TCP_SRC_INTERNAL;
			adj_q     <= pwdata[`TCP_CTRL_ADJ_HI:`TCP_CTRL_ADJ_LO];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			setpoint_q <= 16'sh0000;
			bias_q     <= 16'sh0000;
			afilt_q    <= `TCP_RST_AFILT;
			dead_q     <= `TCP_RST_DEAD;
		end else begin
			if (wr_set) setpoint_q <= sat(wsig, -`TCP_TRQ_MAX, `TCP_TRQ_MAX);
			if (wr_bias) bias_q <= sat(wsig, -`TCP_BIAS_MAX, `TCP_BIAS_MAX);
			if (wr_afilt) afilt_q <= sat(wuns, 32'sh0, `TCP_AFILT_MAX);
			if (wr_dead) dead_q <= sat(wuns, 32'sh0, `TCP_DEAD_MAX);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			offset_q <= 16'sh0000;
		end else if (cal_req) begin
			offset_q <= cal_val;
		end else if (wr_off) begin
			offset_q <= sat(wsig, -`TCP_OFFSET_MAX, `TCP_OFFSET_MAX);
		end
	end

	// Hardware loading wins over a software write of the same register.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tfilt_q <= `TCP_RST_TFILT;
		end else if (auto_tf) begin
			tfilt_q <= `TCP_TFILT_AUTO;
		end else if (wr_tfilt) begin
			tfilt_q <= sat(wuns, `TCP_TFILT_MIN, `TCP_TFILT_MAX);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fwd_q <= `TCP_RST_LIMIT;
			rev_q <= `TCP_RST_LIMIT;
		end else begin
			if (wr_fwd) fwd_q <= sat(wuns, 32'sh0, `TCP_TRQ_MAX);
			if (wr_rev) rev_q <= sat(wuns, 32'sh0, `TCP_TRQ_MAX);
		end
	end

	// ----------------------------------------------------------------
	// Filter tick
	// ----------------------------------------------------------------
	logic [15:0] tick_cnt_q;
	logic        tick;

	assign tick = (tick_cnt_q == 16'(`TCP_TICK_CYC - 1));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_cnt_q <= 16'h0000;
		end else begin
			tick_cnt_q <= tick ? 16'h0000 : tick_cnt_q + 16'h0001;
		end
	end

	// ----------------------------------------------------------------
	// Channel one conditioning
	// ----------------------------------------------------------------
	logic signed [17:0] biased;
	logic        [17:0] biased_abs;
	logic               in_dead;
	tcp_val_t           cond_d;
	tcp_val_t           cond_q;
	tcp_val_t           ai1_mv;
	tcp_val_t           ai1_trq;

	// Bias is the input voltage that maps to zero, so it is subtracted.
	assign biased     = 18'(analog_channel_one) - 18'(offset_q) - 18'(bias_q);
	assign biased_abs = biased[17] ? 18'(-biased) : 18'(biased);
	assign in_dead    = biased_abs <= {2'b00, dead_q};
	assign cond_d     = in_dead ? 16'sh0000
		: sat(32'(biased), -`TCP_AI_FULL_MV, `TCP_AI_FULL_MV);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cond_q <= 16'sh0000;
		end else begin
			cond_q <= cond_d;
		end
	end

	tcp_lpf u_ai_lpf (
		.clk   (pclk),
		.rst_n (presetn),
		.tick  (tick),
		.tau   (afilt_q),
		.x     (cond_q),
		.y     (ai1_mv)
	);

	assign ai1_trq = sat(32'(ai1_mv) * `TCP_AI_GAIN_NUM / `TCP_AI_GAIN_DEN,
		-`TCP_TRQ_MAX, `TCP_TRQ_MAX);

	// ----------------------------------------------------------------
	// Command selection and filtering
	// ----------------------------------------------------------------
	logic     use_analog;
	tcp_val_t sel_cmd;
	tcp_val_t filt_cmd;

	assign use_analog = HAS_ANALOG && (src_q == TCP_SRC_ANALOG);
	assign sel_cmd    = use_analog ? ai1_trq : setpoint_q;

	tcp_lpf u_tq_lpf (
		.clk   (pclk),
		.rst_n (presetn),
		.tick  (tick),
		.tau   (tfilt_q),
		.x     (sel_cmd),
		.y     (filt_cmd)
	);

	// ----------------------------------------------------------------
	// Limit
	// ----------------------------------------------------------------
	logic               lim_analog;
	logic        [16:0] ai2_abs;
	logic        [15:0] ai2_lim;
	logic        [15:0] fwd_mag;
	logic        [15:0] rev_mag;
	tcp_val_t           clamped;
	logic               lim_hit;

	assign lim_analog = HAS_ANALOG && (lim_src_q == TCP_SRC_ANALOG);
	assign ai2_abs    = analog_channel_two[15] ? 17'(-17'(analog_channel_two))
		: 17'(analog_channel_two);
	// The analog limit is a magnitude that applies in both directions.
	assign ai2_lim    = sat($signed({15'h0000, ai2_abs}) * `TCP_AI_GAIN_NUM
		/ `TCP_AI_GAIN_DEN, 32'sh0, `TCP_TRQ_MAX);
	assign fwd_mag    = lim_analog ? ai2_lim : fwd_q;
	assign rev_mag    = lim_analog ? ai2_lim : rev_q;

	tcp_clamp u_clamp (
		.x   (filt_cmd),
		.fwd (fwd_mag),
		.rev (rev_mag),
		.y   (clamped),
		.hit (lim_hit)
	);

	tcp_val_t out_q;
	logic     limited_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_q     <= 16'sh0000;
			limited_q <= 1'b0;
		end else begin
			out_q     <= clamped;
			limited_q <= lim_hit;
		end
	end

	assign torque_command_out = out_q;
	assign torque_limited     = limited_q;

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	always_comb begin
		rdata_d = 32'h00000000;
		case (paddr)
			`TCP_OFS_CTRL:     rdata_d = {24'h000000, adj_q, 2'b00,
				lim_src_q == TCP_SRC_ANALOG, src_q == TCP_SRC_ANALOG};
			`TCP_OFS_SETPOINT: rdata_d = 32'(setpoint_q);
			`TCP_OFS_BIAS:     rdata_d = 32'(bias_q);
			`TCP_OFS_AFILT:    rdata_d = {16'h0000, afilt_q};
			`TCP_OFS_DEAD:     rdata_d = {16'h0000, dead_q};
			`TCP_OFS_OFFSET:   rdata_d = 32'(offset_q);
			`TCP_OFS_TFILT:    rdata_d = {16'h0000, tfilt_q};
			`TCP_OFS_FWD:      rdata_d = {16'h0000, fwd_q};
			`TCP_OFS_REV:      rdata_d = {16'h0000, rev_q};
			`TCP_OFS_STATUS:   rdata_d = {30'h00000000, HAS_ANALOG, limited_q};
			`TCP_OFS_CMDOUT:   rdata_d = 32'(out_q);
			default:           rdata_d = 32'h00000000;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h00000000;
		end else if (setup) begin
			prdata_q <= rdata_d;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_src_internal: assert property (
		(src_q == TCP_SRC_INTERNAL) && tick ##1 (src_q == TCP_SRC_INTERNAL)
		|-> sel_cmd == setpoint_q)
		else $error("internal source not selected");

	a_setpoint_range: assert property (
		wr_set |=> (setpoint_q <= 16'sh0BB8) && (setpoint_q >= -16'sh0BB8))
		else $error("setpoint out of range");

	a_no_analog: assert property (
		!HAS_ANALOG |-> !use_analog && !lim_analog)
		else $error("analog path used in a build without it");

	a_cal_capture: assert property (
		cal_req |=> offset_q == $past(cal_val))
		else $error("calibration did not capture channel one");

	a_bias_range: assert property (
		(bias_q <= 16'sh1388) && (bias_q >= -16'sh1388))
		else $error("bias out of range");

	a_dead_zero: assert property (
		in_dead |=> cond_q == 16'sh0000)
		else $error("dead band did not force zero");

	a_afilt_range: assert property (
		afilt_q <= 16'hEA60)
		else $error("analog filter constant out of range");

	a_tfilt_range: assert property (
		(tfilt_q >= 16'h000A) && (tfilt_q <= 16'h09C4))
		else $error("torque filter constant out of range");

	a_auto_filter: assert property (
		auto_tf ##1 auto_tf |-> tfilt_q == `TCP_TFILT_AUTO)
		else $error("self adjustment did not set the filter constant");

	a_limit_pass: assert property (
		!lim_hit |=> torque_command_out == $past(filt_cmd))
		else $error("unlimited command was altered");

	a_limit_cap: assert property (
		(torque_command_out <= 16'sh0BB8) && (torque_command_out >= -16'sh0BB8))
		else $error("output beyond rated range");

	a_lim_internal: assert property (
		!lim_analog |-> (fwd_mag == fwd_q) && (rev_mag == rev_q))
		else $error("internal limits not applied");

	a_flag_follow: assert property (
		lim_hit |=> torque_limited && (torque_command_out == $past(clamped)))
		else $error("limited flag missing");

endmodule

// ===== test/tcp_host_model.sv
// Host-side model that supplies the two analog channels of the torque command path.
// Assumes the converter hands over samples already synchronous to pclk.
`timescale 1ns/10ps

module tcp_host_model (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire tcp_pkg::tcp_val_t level_one,
	input  wire tcp_pkg::tcp_val_t level_two,
	output tcp_pkg::tcp_val_t      analog_channel_one,
	output tcp_pkg::tcp_val_t      analog_channel_two
);
	import tcp_pkg::*;

	// ----------------------------------------------------------------
	// Converter samples
	// ----------------------------------------------------------------
	// Levels change only after a clock edge, so the device never sees a half-updated sample.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			analog_channel_one <= '0;
			analog_channel_two <= '0;
		end else begin
			analog_channel_one <= level_one;
			analog_channel_two <= level_two;
		end
	end

endmodule

// ===== test/tb.sv
// Self-checking bench for the torque command path, driven over APB.
// Assumes the design files and tcp_map.svh are compiled and visible alongside.
`timescale 1ns/10ps
`include "tcp_map.svh"

module tb;
	import tcp_pkg::*;

	logic        pclk, presetn, psel_a, psel_b, penable, pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata_a, prdata_b, last_q;
	logic        pready_a, pready_b, pslverr_a, pslverr_b, last_e, torque_limited;
	tcp_val_t    level_one, level_two, ch_one, ch_two, torque_command_out;
	int          err_total, checks_done, i;

	// ----------------------------------------------------------------
	// Expected tables
	// ----------------------------------------------------------------
	localparam logic [11:0] RST_ADR [0:10] = '{12'h000, 12'h004, 12'h008, 12'h00C, 12'h010,
		12'h014, 12'h018, 12'h01C, 12'h020, 12'h024, 12'h028};
	localparam logic [15:0] RST_VAL [0:10] = '{16'h0010, 16'h0000, 16'h0000, 16'h00C8,
		16'h0014, 16'h0000, 16'h0032, 16'h0BB8, 16'h0BB8, 16'h0002, 16'h0000};
	localparam logic [11:0] SAT_ADR [0:11] = '{12'h01C, 12'h020, 12'h018, 12'h018, 12'h008,
		12'h008, 12'h010, 12'h00C, 12'h014, 12'h008, 12'h00C, 12'h014};
	localparam logic [15:0] SAT_WR [0:11] = '{16'h0FA0, 16'h0FA0, 16'h0005, 16'h0BB8,
		16'h1770, 16'hE890, 16'h07D0, 16'hFDE8, 16'hFC7C, 16'h0000, 16'h0000, 16'h0000};
	localparam logic [15:0] SAT_RD [0:11] = '{16'h0BB8, 16'h0BB8, 16'h000A, 16'h09C4,
		16'h1388, 16'hEC78, 16'h03E8, 16'hEA60, 16'hFE0C, 16'h0000, 16'h0000, 16'h0000};

	// ----------------------------------------------------------------
	// Design, second build and host model
	// ----------------------------------------------------------------
	tcp_top #(.HAS_ANALOG(1'b1)) dut (.pclk(pclk), .presetn(presetn), .psel(psel_a),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata_a), .pready(pready_a), .pslverr(pslverr_a),
		.analog_channel_one(ch_one), .analog_channel_two(ch_two),
		.torque_command_out(torque_command_out), .torque_limited(torque_limited));
	// The build without analog inputs shares the bus but has its own select.
	tcp_top #(.HAS_ANALOG(1'b0)) dut_plain (.pclk(pclk), .presetn(presetn), .psel(psel_b),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata_b), .pready(pready_b), .pslverr(pslverr_b),
		.analog_channel_one(ch_one), .analog_channel_two(ch_two),
		.torque_command_out(), .torque_limited());
	tcp_host_model host (.pclk(pclk), .presetn(presetn), .level_one(level_one),
		.level_two(level_two), .analog_channel_one(ch_one), .analog_channel_two(ch_two));

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic timeout(input string what);
		err_total++;
		$display("unexpected timeout waiting for %s", what);
		report_and_stop();
	endtask

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask

	// One transfer: setup cycle, then access held until pready is sampled high.
	task automatic apb(input logic b, input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel_a <= !b;
		psel_b <= b;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (n = 0; n < 20; n++) begin
			@(posedge pclk);
			if ((b ? pready_b : pready_a) === 1'b1) break;
		end
		if (n == 20) timeout("pready");
		last_q = b ? prdata_b : prdata_a;
		last_e = b ? pslverr_b : pslverr_a;
		psel_a <= 1'b0;
		psel_b <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [15:0] d);
		apb(1'b0, 1'b1, a, {{16{d[15]}}, d});
	endtask

	// Upper half may read zero or sign, so only the value half is compared.
	task automatic rd(input logic b, input logic [11:0] a, input logic [15:0] exp);
		apb(b, 1'b0, a, 32'h0000_0000);
		chk("read data", {16'h0000, last_q[15:0]}, {16'h0000, exp});
	endtask

	task automatic wait_cmd(input logic [15:0] exp, input int bound);
		int n;
		for (n = 0; n < bound; n++) begin
			@(posedge pclk);
			if (torque_command_out === exp) break;
		end
		if (n == bound) timeout("torque command");
		chk("torque command", {16'h0000, torque_command_out}, {16'h0000, exp});
	endtask

	// ----------------------------------------------------------------
	// Clock, reset and test sequence
	// ----------------------------------------------------------------
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	initial begin
		presetn = 1'b0;
		{psel_a, psel_b, penable, pwrite} = 4'h0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		level_one = 16'sh0000;
		level_two = 16'sh0000;
		err_total = 0;
		checks_done = 0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		for (i = 0; i < 11; i++) rd(1'b0, RST_ADR[i], RST_VAL[i]);
		$display("test reset_values done");
		rd(1'b0, 12'h02C, 16'h0000);
		chk("pslverr", {31'h0, last_e}, 32'h0000_0001);
		apb(1'b0, 1'b1, 12'h002, 32'h0000_1234);
		chk("pslverr", {31'h0, last_e}, 32'h0000_0001);
		wr(`TCP_OFS_STATUS, 16'h0000);
		chk("pslverr", {31'h0, last_e}, 32'h0000_0000);
		rd(1'b0, `TCP_OFS_STATUS, 16'h0002);
		$display("test bus_errors done");
		for (i = 0; i < 12; i++) begin
			wr(SAT_ADR[i], SAT_WR[i]);
			rd(1'b0, SAT_ADR[i], SAT_RD[i]);
		end
		$display("test saturation done");
		wr(`TCP_OFS_TFILT, 16'h012C);
		wr(`TCP_OFS_CTRL, 16'h0000);
		rd(1'b0, `TCP_OFS_TFILT, 16'h0032);
		wr(`TCP_OFS_TFILT, 16'h0190);
		rd(1'b0, `TCP_OFS_TFILT, 16'h0032);
		wr(`TCP_OFS_CTRL, 16'h0010);
		wr(`TCP_OFS_TFILT, 16'h000A);
		rd(1'b0, `TCP_OFS_TFILT, 16'h000A);
		$display("test self_adjust done");
		apb(1'b1, 1'b1, `TCP_OFS_CTRL, 32'h0000_0013);
		rd(1'b1, `TCP_OFS_CTRL, 16'h0010);
		rd(1'b1, `TCP_OFS_STATUS, 16'h0000);
		$display("test plain_build done");
		// Filter gain is 1/8 at constant 10, so the first tick lands at 125.
		wr(`TCP_OFS_FWD, 16'h0064);
		wr(`TCP_OFS_SETPOINT, 16'h03E8);
		wait_cmd(16'h0064, 3000);
		chk("limited", {31'h0, torque_limited}, 32'h0000_0001);
		wr(`TCP_OFS_FWD, 16'h0BB8);
		rd(1'b0, `TCP_OFS_CMDOUT, 16'h007D);
		chk("limited", {31'h0, torque_limited}, 32'h0000_0000);
		$display("test internal_forward done");
		level_one <= -16'sd5000;
		level_two <= 16'sd1000;
		wr(`TCP_OFS_CTRL, 16'h0013);
		wait_cmd(16'hFED4, 30000);
		chk("limited", {31'h0, torque_limited}, 32'h0000_0001);
		rd(1'b0, `TCP_OFS_STATUS, 16'h0003);
		wr(`TCP_OFS_REV, 16'h00C8);
		wr(`TCP_OFS_CTRL, 16'h0011);
		wait_cmd(16'hFF38, 50);
		$display("test limits done");
		level_one <= 16'sd123;
		repeat (3) @(posedge pclk);
		wr(`TCP_OFS_CTRL, 16'h0014);
		rd(1'b0, `TCP_OFS_OFFSET, 16'h007B);
		rd(1'b0, `TCP_OFS_CTRL, 16'h0010);
		level_one <= 16'sd800;
		repeat (3) @(posedge pclk);
		wr(`TCP_OFS_CTRL, 16'h0014);
		rd(1'b0, `TCP_OFS_OFFSET, 16'h01F4);
		$display("test calibration done");
		report_and_stop();
	end

endmodule
